// ### design/ascp_map.vh
// Constants for the addressed serial command parser.
// Assumes inclusion by bare name from design files.
`ifndef ASCP_MAP_VH
`define ASCP_MAP_VH
// -----------------------------------------------------------------
// Byte values and the command-flag bit position
// -----------------------------------------------------------------
`define ASCP_CMD_BIT 7
`define ASCP_LEAD_ADDR 8'haa
`define ASCP_LEAD_SPEED 8'hff
`define ASCP_OP_RELEASE 7'h03
`define ASCP_NODE_BCAST 8'hfe
`define ASCP_NODE_RST 7'h0d
`define ASCP_NODE_MAX 7'h7f
`define ASCP_SPEED_ZERO 8'h7f
`define ASCP_SPEED_MAX 8'hfe
`endif

// ### design/ascp_lockout.v
// Start-lockout holder for the serial command parser.
// Assumes release and re-arm strobes are one-cycle pulses on core_clk_in.
`timescale 1ns/1ps
`default_nettype none
module ascp_lockout (
  // Clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // Controls
  input wire lockout_en_in,
  input wire serial_src_in,
  input wire release_in,
  input wire error_stop_in,
  // Status
  output reg locked_out
);
  // -----------------------------------------------------------------
  // Lockout flag
  // -----------------------------------------------------------------
  reg armed_q;
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      armed_q <= 1'b1;
    end else if (error_stop_in) begin
      // Re-arm wins over a release in the same cycle, safer side
      armed_q <= 1'b1;
    end else if (release_in) begin
      armed_q <= 1'b0;
    end
  end
  always @* begin
    locked_out = armed_q & lockout_en_in & serial_src_in;
  end
endmodule // ascp_lockout
`default_nettype wire

// ### design/ascp_parser.v
// Binary serial command parser: short, addressed and three-byte framings.
// Assumes received bytes arrive as one-cycle strobes from a UART on core_clk_in.
`timescale 1ns/1ps
`default_nettype none
`include "ascp_map.vh"
module ascp_parser (
  // Clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // Received byte stream
  input wire rx_valid_in,
  input wire [7:0] rx_byte_in,
  // Configuration
  input wire node_load_in,
  input wire [7:0] node_value_in,
  input wire lockout_en_in,
  input wire serial_src_in,
  input wire error_stop_in,
  // Decoded command for the handlers
  output reg cmd_valid_out,
  output reg [6:0] cmd_op_out,
  output reg cmd_addressed_out,
  output reg data_valid_out,
  output reg [6:0] data_out,
  output reg baud_mark_out,
  // Three-byte speed result
  output reg speed_valid_out,
  output reg signed [7:0] speed_out,
  // Lockout and status
  output reg release_out,
  output reg locked_out,
  output reg reply_block_out,
  output reg [6:0] node_out
);
  // -----------------------------------------------------------------
  // States
  // -----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR_NODE = 3'd1;
  localparam [2:0] ST_ADDR_OP = 3'd2;
  localparam [2:0] ST_BODY = 3'd3;
  localparam [2:0] ST_SSC_NODE = 3'd4;
  localparam [2:0] ST_SSC_SPEED = 3'd5;
  localparam [2:0] ST_SKIP = 3'd6;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg ssc_hit_q;
  reg ssc_hit_d;
  reg [6:0] node_q;
  reg cmd_valid_d;
  reg [6:0] cmd_op_d;
  reg cmd_addr_d;
  reg data_valid_d;
  reg [6:0] data_d;
  reg baud_d;
  reg speed_valid_d;
  reg signed [7:0] speed_d;
  reg release_d;
  wire is_cmd;
  wire lock_now;

  assign is_cmd = rx_byte_in[`ASCP_CMD_BIT];

  // -----------------------------------------------------------------
  // Node number
  // -----------------------------------------------------------------
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      node_q <= `ASCP_NODE_RST;
    end else if (node_load_in) begin
      // Out-of-range values saturate instead of wrapping
      node_q <= node_value_in[7] ? `ASCP_NODE_MAX : node_value_in[6:0];
    end
  end

  // -----------------------------------------------------------------
  // Byte decoder
  // -----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    ssc_hit_d = ssc_hit_q;
    cmd_valid_d = 1'b0;
    cmd_op_d = cmd_op_out;
    cmd_addr_d = cmd_addressed_out;
    data_valid_d = 1'b0;
    data_d = data_out;
    baud_d = 1'b0;
    speed_valid_d = 1'b0;
    speed_d = speed_out;
    release_d = 1'b0;
    if (rx_valid_in) begin
      if (state_q == ST_SSC_NODE) begin
        // Full eight-bit node byte, any value but 255 from the host
        ssc_hit_d = (rx_byte_in == {1'b0, node_q}) || (rx_byte_in == `ASCP_NODE_BCAST);
        state_d = ST_SSC_SPEED;
      end else if (state_q == ST_SSC_SPEED) begin
        if (ssc_hit_q) begin
          speed_valid_d = 1'b1;
          speed_d = rx_byte_in - `ASCP_SPEED_ZERO;
        end
        state_d = ST_IDLE;
      end else if (is_cmd) begin
        // Outside a three-byte packet, any command byte restarts framing, dropping a partial packet
        if (rx_byte_in == `ASCP_LEAD_ADDR) begin
          baud_d = 1'b1;
          state_d = ST_ADDR_NODE;
        end else if (rx_byte_in == `ASCP_LEAD_SPEED) begin
          state_d = ST_SSC_NODE;
        end else begin
          cmd_valid_d = 1'b1;
          cmd_addr_d = 1'b0;
          cmd_op_d = rx_byte_in[6:0];
          release_d = (rx_byte_in[6:0] == `ASCP_OP_RELEASE);
          state_d = ST_BODY;
        end
      end else begin
        case (state_q)
          ST_ADDR_NODE: begin
            // Mismatch skips the rest until the next command byte
            state_d = (rx_byte_in[6:0] == node_q) ? ST_ADDR_OP : ST_SKIP;
          end
          ST_ADDR_OP: begin
            cmd_valid_d = 1'b1;
            cmd_op_d = rx_byte_in[6:0];
            cmd_addr_d = 1'b1;
            release_d = (rx_byte_in[6:0] == `ASCP_OP_RELEASE);
            state_d = ST_BODY;
          end
          ST_BODY: begin
            data_valid_d = 1'b1;
            data_d = rx_byte_in[6:0];
          end
          ST_IDLE: begin
            state_d = ST_IDLE;
          end
          ST_SKIP: begin
            state_d = ST_SKIP;
          end
          default: begin
            state_d = ST_IDLE;
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------
  // Registers
  // -----------------------------------------------------------------
  always @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      ssc_hit_q <= 1'b0;
      cmd_valid_out <= 1'b0;
      cmd_op_out <= 7'h00;
      cmd_addressed_out <= 1'b0;
      data_valid_out <= 1'b0;
      data_out <= 7'h00;
      baud_mark_out <= 1'b0;
      speed_valid_out <= 1'b0;
      speed_out <= 8'sh00;
      release_out <= 1'b0;
      locked_out <= 1'b1;
      reply_block_out <= 1'b0;
      node_out <= `ASCP_NODE_RST;
    end else begin
      state_q <= state_d;
      ssc_hit_q <= ssc_hit_d;
      cmd_valid_out <= cmd_valid_d;
      cmd_op_out <= cmd_op_d;
      cmd_addressed_out <= cmd_addr_d;
      data_valid_out <= data_valid_d;
      data_out <= data_d;
      baud_mark_out <= baud_d;
      speed_valid_out <= speed_valid_d;
      speed_out <= speed_d;
      release_out <= release_d;
      locked_out <= lock_now;
      // Release produces no answer; the reply path must stay quiet
      reply_block_out <= release_d;
      node_out <= node_q;
    end
  end

  // -----------------------------------------------------------------
  // Lockout
  // -----------------------------------------------------------------
  ascp_lockout u_lockout (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .lockout_en_in(lockout_en_in),
    .serial_src_in(serial_src_in),
    .release_in(release_out),
    .error_stop_in(error_stop_in),
    .locked_out(lock_now)
  );
endmodule // ascp_parser
`default_nettype wire

// ### tb/ascp_parser_props.sv
// Checker on the parser ports: framing, node filter, lockout timing.
// Assumes one clock domain; bound onto every parser instance.
`timescale 1ns/1ps
`default_nettype none
module ascp_parser_props (
  // Clock, reset and inputs
  input wire logic core_clk_in, sys_rst_in, rx_valid_in, node_load_in, error_stop_in,
  input wire logic lockout_en_in, serial_src_in,
  input wire logic [7:0] rx_byte_in, node_value_in,
  // Outputs watched
  input wire logic cmd_valid_out, cmd_addressed_out, baud_mark_out, speed_valid_out,
  input wire logic release_out, locked_out, reply_block_out,
  input wire logic [6:0] cmd_op_out, node_out,
  input wire logic signed [7:0] speed_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Bytes still owed to a three-byte packet; those are taken raw
  logic [1:0] ssc_left_q;
  always @(posedge core_clk_in) begin
    if (sys_rst_in) ssc_left_q <= 2'd0;
    else if (rx_valid_in && ssc_left_q != 2'd0) ssc_left_q <= ssc_left_q - 2'd1;
    else if (rx_valid_in && rx_byte_in == 8'hff) ssc_left_q <= 2'd2;
  end
  a_baud_mark: assert property (rx_valid_in && rx_byte_in == 8'haa && ssc_left_q == 2'd0 |=> baud_mark_out)
    else $error("baud mark missing");
  a_short_release: assert property (rx_valid_in && rx_byte_in == 8'h83 && ssc_left_q == 2'd0 |=>
    release_out && cmd_op_out == 7'h03 && !cmd_addressed_out) else $error("short release missed");
  a_reply_held: assert property (release_out |-> reply_block_out)
    else $error("reply not suppressed");
  a_lock_drop: assert property (release_out && !error_stop_in && !$past(error_stop_in) |-> ##2 !locked_out)
    else $error("lockout not lifted");
  a_error_rearm: assert property (error_stop_in ##1 lockout_en_in && serial_src_in |=> locked_out)
    else $error("lockout not re-armed");
  a_node_clamp: assert property (node_load_in && node_value_in[7] |-> ##2 node_out == 7'h7f)
    else $error("node not clamped");
  a_speed_bcast: assert property (rx_valid_in && rx_byte_in == 8'hff && ssc_left_q == 2'd0
    ##1 rx_valid_in && rx_byte_in == 8'hfe
    ##1 rx_valid_in && rx_byte_in != 8'hff |=> speed_valid_out && speed_out == $past(rx_byte_in) - 8'd127)
    else $error("broadcast speed wrong");
  a_addr_reject: assert property (rx_valid_in && rx_byte_in == 8'haa && ssc_left_q == 2'd0
    ##1 rx_valid_in && !rx_byte_in[7]
    && rx_byte_in[6:0] != node_out ##1 rx_valid_in && rx_byte_in == 8'h03 |=> !cmd_valid_out && !release_out)
    else $error("foreign packet acted on");
endmodule // ascp_parser_props
bind ascp_parser ascp_parser_props u_ascp_parser_props (.*);
`default_nettype wire

// ### tb/ascp_host.sv
// Host model: drives the shared serial byte stream.
// Assumes callers enter its tasks just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ascp_host (
  input wire logic clk_in,
  output logic valid_out,
  output logic [7:0] byte_out
);
  initial begin
    valid_out = 1'b0;
    byte_out = 8'h00;
  end
  // One byte per edge; consecutive calls give a burst
  task send(input logic [7:0] b);
    valid_out <= 1'b1;
    byte_out <= b;
    @(posedge clk_in);
  endtask
  // Released line shows the inverse, so no stale byte looks valid
  task idle;
    valid_out <= 1'b0;
    byte_out <= ~byte_out;
    @(posedge clk_in);
  endtask
endmodule // ascp_host
`default_nettype wire

// ### tb/ascp_parser_tb.sv
// Self-checking bench for the serial command parser.
// Assumes one 40 MHz clock; the host model drives the byte stream.
`timescale 1ns/1ps
`default_nettype none
module ascp_parser_tb;
  logic clk = 1'b0, rst = 1'b1, load = 1'b0, en = 1'b1, src = 1'b1, err = 1'b0;
  logic [7:0] nval = 8'h00, r, n;
  wire v;
  wire [7:0] b;
  logic cv, ca, sv, rel, lk, dv;
  logic [6:0] op, node, dout;
  logic signed [7:0] spd;
  logic [9:0] notes[$];
  int miscompares = 0, checks = 0, seed = 71, i, k;
  initial forever #12.5 clk = ~clk;
  ascp_host u_ascp_host (.clk_in(clk), .valid_out(v), .byte_out(b));
  ascp_parser u_ascp_parser (.core_clk_in(clk), .sys_rst_in(rst), .rx_valid_in(v), .rx_byte_in(b),
    .node_load_in(load), .node_value_in(nval), .lockout_en_in(en), .serial_src_in(src), .error_stop_in(err),
    .cmd_valid_out(cv), .cmd_op_out(op), .cmd_addressed_out(ca), .data_valid_out(dv), .data_out(dout),
    .baud_mark_out(), .speed_valid_out(sv), .speed_out(spd), .release_out(rel), .locked_out(lk),
    .reply_block_out(), .node_out(node));
  task automatic check(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task pkt(input logic [7:0] a, input logic [7:0] c, input logic [7:0] d);
    u_ascp_host.send(a);
    u_ascp_host.send(c);
    u_ascp_host.send(d);
    u_ascp_host.idle;
  endtask
  task wait_lock(input logic e);
    for (i = 0; i < 8 && lk !== e; i++) @(posedge clk);
    check({9'h0, lk}, {9'h0, e});
    if (i == 8) close_out;
  endtask
  // Result watcher: every command, data and speed event must match the oldest note
  always @(posedge clk) if (!rst && (cv || sv || dv)) begin
    if (notes.size() == 0) check(10'h3ff, 10'h000);
    else check(dv ? {3'b110, dout} : cv ? {1'b0, rel, ca, op} : {2'd2, spd}, notes.pop_front());
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({3'h0, node}, 10'h00d);
    check({9'h0, lk}, 10'h001);
    notes.push_back({3'b000, 7'h05});
    notes.push_back({2'b11, 8'h00});
    notes.push_back({2'b11, 8'h64});
    u_ascp_host.send(8'haa);
    pkt(8'h85, 8'h00, 8'h64);
    notes.push_back({3'b011, 7'h03});
    pkt(8'haa, 8'h0d, 8'h03);
    wait_lock(1'b0);
    $display("test release done");
    err <= 1'b1;
    @(posedge clk);
    err <= 1'b0;
    wait_lock(1'b1);
    en <= 1'b0;
    wait_lock(1'b0);
    en <= 1'b1;
    wait_lock(1'b1);
    src <= 1'b0;
    wait_lock(1'b0);
    src <= 1'b1;
    wait_lock(1'b1);
    notes.push_back({3'b010, 7'h03});
    u_ascp_host.send(8'h83);
    u_ascp_host.idle;
    wait_lock(1'b0);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    wait_lock(1'b1);
    pkt(8'haa, 8'h0e, 8'h03);
    notes.push_back({3'b000, 7'h05});
    pkt(8'haa, 8'h0d, 8'h85);
    notes.push_back({3'b001, 7'h05});
    pkt(8'haa, 8'h0d, 8'h05);
    $display("test addressed done");
    for (k = 0; k < 12; k++) begin
      r = (k < 3) ? 8'h7f * k[7:0] : $random(seed);
      if (r == 8'hff) r = 8'hfe;
      n = (k % 4 == 3) ? 8'h20 : (k % 2 == 0) ? 8'h0d : 8'hfe;
      if (n != 8'h20) notes.push_back({2'd2, r - 8'd127});
      pkt(8'hff, n, r);
    end
    $display("test speed done");
    load <= 1'b1;
    nval <= 8'h90;
    @(posedge clk);
    load <= 1'b0;
    repeat (2) @(posedge clk);
    check({3'h0, node}, 10'h07f);
    notes.push_back({3'b001, 7'h09});
    pkt(8'haa, 8'h7f, 8'h09);
    repeat (4) @(posedge clk);
    check(notes.size(), 10'h000);
    $display("test node done");
    close_out;
  end
endmodule // ascp_parser_tb
`default_nettype wire
